// [bench/power_wake_and_irq_enable_test.sv]
// Register-level bench for the power and wake block.
// Assumes the wake port model and the bound monitor.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module power_wake_and_irq_enable_test;
  localparam logic [15:0] PA = pwr_wake_pkg::PWR_CTRL_OFFSET;
  localparam logic [15:0] IA = pwr_wake_pkg::IRQ_EN_OFFSET;
  localparam int          EN [9] = '{4, 4, 7, 8, 9, 11, 11, 12, 14};
  logic                   ref_clk = 1'b0;
  logic                   resetn = 1'b0;
  logic [15:0]            reg_addr = 16'h0000;
  logic [15:0]            reg_wdata = 16'h0000;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic                   boost_low = 1'b0;
  logic [8:0]             poke = 9'h000;
  logic [15:0]            reg_rdata, v;
  pwr_wake_pkg::irq_vec_t irq_pending = '0;
  pwr_wake_pkg::irq_vec_t irq_req;
  pwr_wake_pkg::wake_pins_t wake_pins;
  logic                   gp_clr, t1_clr, t0_clr, cpu_run, clk_gate_en, analog_pwr_en, fsp_discard, spi_discard;
  int                     n_mismatch = 0;
  int                     check_count = 0;
  int                     cycles = 0;
  always #2 ref_clk = ~ref_clk;
  wake_port_model i_far (.ref_clk(ref_clk), .resetn(resetn), .poke(poke), .wake_pins(wake_pins));
  power_wake_and_irq_enable #(.RESUME_CYCLES(8)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_pins(wake_pins), .boost_low(boost_low),
    .irq_pending(irq_pending), .irq_req(irq_req), .gp_pend_clr(gp_clr), .tmr1_pend_clr(t1_clr),
    .tmr0_pend_clr(t0_clr), .cpu_run(cpu_run), .clk_gate_en(clk_gate_en), .analog_pwr_en(analog_pwr_en),
    .fsp_discard(fsp_discard), .spi_discard(spi_discard));
  // ****************************************
  // Bus tasks and helpers
  // ****************************************
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge ref_clk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic poke_pin(input int i);
    @(posedge ref_clk) poke <= 9'h001 << i;
    @(posedge ref_clk) poke <= 9'h000;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_run();
    for (int k = 0; k < 40 && cpu_run !== 1'b1; k++) @(posedge ref_clk);
    #1;
  endtask
  function automatic pwr_wake_pkg::irq_vec_t gate(input logic [15:0] m);
    gate = '0;
    gate.otg_change_vector = m[12];
    gate.spi = {3{m[11]}};
    gate.usb2 = {8{m[9]}};
    gate.usb1 = {8{m[8]}};
    gate.fsp = {2{m[7]}};
    gate.inbound_mailbox_irq = m[6];
    gate.outbound_mailbox_irq = m[5];
    gate.uart = {2{m[3]}};
    gate.gpio = m[2];
    gate.timer1_irq = m[1];
    gate.timer0_irq = m[0];
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(PA, v); `CHK(v, pwr_wake_pkg::PWR_RESET)
    rd(IA, v); `CHK(v, pwr_wake_pkg::IE_RESET)
    rd(16'hc00c, v); `CHK(v, 16'h0000)
    wr(PA, 16'h5b94);
    rd(PA, v); `CHK(v, pwr_wake_pkg::PWR_WAKE_MASK)
    `CHK(cpu_run, 1'b1)
    wr(PA, 16'h0000);
    @(posedge ref_clk) irq_pending <= '1;
    for (int b = 0; b < 16; b++) begin
      wr(IA, (16'h0001 << b) & pwr_wake_pkg::IE_WR_MASK);
      `CHK({gp_clr, t1_clr, t0_clr}, {b == 3, b == 2, b == 1})
      rd(IA, v); `CHK(v, (16'h0001 << b) & pwr_wake_pkg::IE_WR_MASK)
      `CHK(irq_req, gate(16'h0001 << b))
    end
    @(posedge ref_clk) irq_pending <= '0;
    wr(IA, 16'h0001);
    wr(PA, 16'h0001);
    `CHK({cpu_run, clk_gate_en}, 2'b01)
    @(posedge ref_clk) irq_pending.timer0_irq <= 1'b1;
    wait_run(); `CHK(cpu_run, 1'b1)
    @(posedge ref_clk) irq_pending <= '0;
    @(posedge ref_clk) boost_low <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(PA, v); `CHK(v[2], 1'b1)
    @(posedge ref_clk) boost_low <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wr(PA, 16'h0001 << EN[i]);
      poke_pin(i);
      poke_pin(i);
      `CHK(cpu_run, 1'b1)
      wr(PA, (16'h0001 << EN[i]) | 16'h0002);
      `CHK({cpu_run, clk_gate_en, analog_pwr_en}, 3'b000)
      poke_pin(i);
      `CHK({fsp_discard, spi_discard}, {i == 4, i == 3})
      `CHK(clk_gate_en, 1'b1)
      wait_run(); `CHK(cpu_run, 1'b1)
      poke_pin(i);
    end
    wr(PA, 16'h0013);
    `CHK({cpu_run, clk_gate_en}, 2'b00)
    poke_pin(0);
    wait_run(); `CHK(cpu_run, 1'b1)
    poke_pin(0);
    wr(PA, 16'h0002);
    poke_pin(1);
    repeat (20) @(posedge ref_clk);
    #1 `CHK(cpu_run, 1'b0)
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(PA, v); `CHK(v, pwr_wake_pkg::PWR_RESET)
    `CHK(cpu_run, 1'b1)
    wrap_up();
  end
endmodule

// [bench/pwr_wake_monitor.sv]
// Concurrent checks on the power and wake block ports.
// Assumes one clock, ref_clk, with resetn as its asynchronous reset.
`timescale 1ns/1ps
module pwr_wake_monitor #(
  parameter int RESUME_CYCLES = pwr_wake_pkg::RESUME_CYCLES
) (
  input wire logic                    ref_clk,
  input wire logic                    resetn,
  input wire logic [15:0]             reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_rdata,
  input wire pwr_wake_pkg::irq_vec_t  irq_pending,
  input wire pwr_wake_pkg::irq_vec_t  irq_req,
  input wire logic                    tmr0_pend_clr,
  input wire logic                    cpu_run,
  input wire logic                    clk_gate_en,
  input wire logic                    analog_pwr_en
);
  // ****************************************
  // Shadow of the enable mask, resume timer
  // ****************************************
  logic [15:0] ie_q;
  int          wait_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) ie_q <= 16'h0000;
    else if (reg_wr && reg_addr == pwr_wake_pkg::IRQ_EN_OFFSET) ie_q <= reg_wdata & pwr_wake_pkg::IE_WR_MASK;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) wait_q <= 0;
    else if (!clk_gate_en) wait_q <= 1;
    else if (wait_q != 0 && !cpu_run) wait_q <= wait_q + 1;
    else wait_q <= 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_wr_ie;
    reg_wr && reg_addr == pwr_wake_pkg::IRQ_EN_OFFSET;
  endsequence
  sequence s_stopped;
    !clk_gate_en && !cpu_run && !analog_pwr_en;
  endsequence
  property p_rd_unmapped;
    reg_rd && reg_addr != pwr_wake_pkg::IRQ_EN_OFFSET && reg_addr != pwr_wake_pkg::PWR_CTRL_OFFSET
      |=> reg_rdata == 16'h0000;
  endproperty
  property p_rd_ie;
    reg_rd && reg_addr == pwr_wake_pkg::IRQ_EN_OFFSET |=> reg_rdata == $past(ie_q);
  endproperty
  property p_req_subset;
    1'b1 |=> (irq_req & ~$past(irq_pending)) == '0;
  endproperty
  property p_tmr0_gate;
    1'b1 |=> irq_req.timer0_irq == ($past(irq_pending.timer0_irq) && $past(ie_q[0]));
  endproperty
  property p_usb2_gate;
    1'b1 |=> irq_req.usb2 == ($past(irq_pending.usb2) & {8{$past(ie_q[9])}});
  endproperty
  property p_tmr0_clr;
    s_wr_ie ##0 (!reg_wdata[0] && ie_q[0]) |=> tmr0_pend_clr;
  endproperty
  property p_sleep;
    reg_wr && reg_addr == pwr_wake_pkg::PWR_CTRL_OFFSET && reg_wdata[1] |=> s_stopped;
  endproperty
  property p_halt;
    reg_wr && reg_addr == pwr_wake_pkg::PWR_CTRL_OFFSET && reg_wdata[1:0] == 2'b01 && cpu_run
      |=> !cpu_run && clk_gate_en;
  endproperty
  property p_one_mode;
    !clk_gate_en |-> !cpu_run;
  endproperty
  property p_resume;
    wait_q <= RESUME_CYCLES + 4;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_rd_ie: assert property (p_rd_ie) else $error("enable readback wrong");
  a_req_subset: assert property (p_req_subset) else $error("request without pending");
  a_tmr0_gate: assert property (p_tmr0_gate) else $error("timer0 gate wrong");
  a_usb2_gate: assert property (p_usb2_gate) else $error("usb2 gate wrong");
  a_tmr0_clr: assert property (p_tmr0_clr) else $error("timer0 pending not cleared");
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  a_halt: assert property (p_halt) else $error("halt not entered");
  a_one_mode: assert property (p_one_mode) else $error("cpu runs while clock stopped");
  a_resume: assert property (p_resume) else $error("restart too late");
endmodule

bind power_wake_and_irq_enable pwr_wake_monitor #(.RESUME_CYCLES(RESUME_CYCLES)) i_mon (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pending(irq_pending), .irq_req(irq_req),
  .tmr0_pend_clr(tmr0_pend_clr), .cpu_run(cpu_run), .clk_gate_en(clk_gate_en), .analog_pwr_en(analog_pwr_en)
);

// [bench/wake_port_model.sv]
// Wake-capable pins at the far side; each poke bit flips one pin.
// Assumes the bench pulses poke for one cycle.
`timescale 1ns/1ps
module wake_port_model (
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  input  wire logic [8:0]     poke,
  output pwr_wake_pkg::wake_pins_t wake_pins
);
  // ****************************************
  // Idle high, host read strobe idle low
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) wake_pins <= pwr_wake_pkg::wake_pins_t'(9'h1fb);
    else wake_pins <= pwr_wake_pkg::wake_pins_t'(wake_pins ^ poke);
  end
endmodule

// [hw/pin_sync.sv]
// Two-stage synchroniser for one asynchronous pin.
// Assumes ref_clk is the only clock.
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      pin_s
);
  logic meta_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      pin_s  <= RST_VAL;
    end else begin
      meta_q <= pin;
      pin_s  <= meta_q;
    end
  end
endmodule

// [hw/power_wake_and_irq_enable.sv]
// Power mode, wake enable and interrupt enable control.
// Assumes the CPU drives the register port on ref_clk; wake pins are asynchronous.
//
// Contract
// - Power bit 14 lets USB port 2 activity wake from sleep, no interrupt.
// - Power bit 12 lets USB port 1 activity wake from sleep, no interrupt.
// - Power bit 11 lets OTG bus voltage or id change wake the chip.
// - Power bit 9 lets fast serial receive edges wake; that byte is dropped.
// - Power bit 8 lets slave select falling edge wake; that byte is dropped.
// - Power bit 7 lets a host parallel port read wake the chip.
// - Power bit 4 lets either edge of GP pin 24 or 25 wake.
// - Power bit 2 is read only, one while booster rails are low.
// - Writing one to bit 1 enters sleep at once; clocks stop, state kept.
// - Any enabled wake source ends sleep; CPU restarts within 0.5 ms.
// - Wake enable bits act only while sleeping.
// - Only one of sleep or halt is active at a time.
// - Writing one to bit 0 halts only the CPU; writing zero does nothing.
// - Any enabled interrupt ends halt.
// - Enable bit 12 gates the OTG change interrupt.
// - Enable bit 11 gates SPI transmit, receive and block done.
// - Enable bit 9 gates all USB port 2 interrupts.
// - Enable bit 8 gates all USB port 1 interrupts.
// - Enable bit 7 gates both fast serial port interrupts.
// - Enable bits 6 and 5 gate inbound and outbound mailbox.
// - Enable bit 3 gates UART transmit and receive.
// - Bits 2,1,0 gate GPIO and timers; clearing also discards pending.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module power_wake_and_irq_enable #(
  parameter int RESUME_CYCLES = pwr_wake_pkg::RESUME_CYCLES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic [15:0]             reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [15:0]                  reg_rdata,
  input  wire pwr_wake_pkg::wake_pins_t wake_pins,
  input  wire logic                    boost_low,
  input  wire pwr_wake_pkg::irq_vec_t  irq_pending,
  output pwr_wake_pkg::irq_vec_t       irq_req,
  output logic                         gp_pend_clr,
  output logic                         tmr1_pend_clr,
  output logic                         tmr0_pend_clr,
  output logic                         cpu_run,
  output logic                         clk_gate_en,
  output logic                         analog_pwr_en,
  output logic                         fsp_discard,
  output logic                         spi_discard
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int NPIN = $bits(pwr_wake_pkg::wake_pins_t);
  logic [NPIN-1:0] pins_s;
  logic [NPIN-1:0] pins_prev_q;
  logic            boost_s;
  pwr_wake_pkg::wake_pins_t pin_now;
  pwr_wake_pkg::wake_pins_t pin_old;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      pin_sync #(.RST_VAL(1'b1)) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pin     (wake_pins[gi]),
        .pin_s   (pins_s[gi])
      );
    end
  endgenerate

  pin_sync #(.RST_VAL(1'b0)) u_boost (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (boost_low),
    .pin_s   (boost_s)
  );

  // Previous synced levels for edge detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pins_prev_q <= '1;
    end else begin
      pins_prev_q <= pins_s;
    end
  end

  assign pin_now = pins_s;
  assign pin_old = pins_prev_q;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0]            pwr_q;
  logic [15:0]            ie_q;
  pwr_wake_pkg::pm_state_t state_q;
  logic [31:0]            resume_cnt_q;
  logic                   wr_pwr;
  logic                   wr_ie;
  logic                   wake_hit;
  logic                   any_irq;
  logic [15:0]            ie_d;
  logic                   sleep_wr;
  logic                   halt_wr;
  logic                   sleep_exit;

  assign wr_pwr = reg_wr && (reg_addr == pwr_wake_pkg::PWR_CTRL_OFFSET);
  assign wr_ie  = reg_wr && (reg_addr == pwr_wake_pkg::IRQ_EN_OFFSET);
  assign ie_d   = reg_wdata & pwr_wake_pkg::IE_WR_MASK;

  // Mode requests; sleep wins when both bits are written
  assign sleep_wr = wr_pwr && reg_wdata[pwr_wake_pkg::PWR_SLEEP_BIT];
  assign halt_wr  = wr_pwr && reg_wdata[pwr_wake_pkg::PWR_HALT_BIT] && !sleep_wr;

  // Wake enables stored as written; reserved bits held at zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_q <= pwr_wake_pkg::PWR_RESET;
    end else if (wr_pwr) begin
      pwr_q <= reg_wdata & pwr_wake_pkg::PWR_WAKE_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ie_q <= pwr_wake_pkg::IE_RESET;
    end else if (wr_ie) begin
      ie_q <= ie_d;
    end
  end

  // ************************************************************
  // Wake detection
  // ************************************************************
  logic usb2_act;
  logic usb1_act;
  logic otg_act;
  logic fsp_act;
  logic spi_act;
  logic host_act;
  logic gp_act;

  assign usb2_act = pin_now.usb2 ^ pin_old.usb2;
  assign usb1_act = pin_now.usb1 ^ pin_old.usb1;
  assign otg_act  = (pin_now.bus_voltage_valid ^ pin_old.bus_voltage_valid) |
                    (pin_now.otg_id ^ pin_old.otg_id);
  assign fsp_act  = pin_now.fsp_rx ^ pin_old.fsp_rx;
  assign spi_act  = pin_old.slave_select_n & ~pin_now.slave_select_n;
  assign host_act = pin_now.host_rd & ~pin_old.host_rd;
  assign gp_act   = |(pin_now.gp_pin ^ pin_old.gp_pin);

  always_comb begin
    wake_hit = 1'b0;
    if (pwr_q[pwr_wake_pkg::PWR_USB2_BIT] && usb2_act) wake_hit = 1'b1;
    if (pwr_q[pwr_wake_pkg::PWR_USB1_BIT] && usb1_act) wake_hit = 1'b1;
    if (pwr_q[pwr_wake_pkg::PWR_OTG_BIT] && otg_act) wake_hit = 1'b1;
    if (pwr_q[pwr_wake_pkg::PWR_FSP_BIT] && fsp_act) wake_hit = 1'b1;
    if (pwr_q[pwr_wake_pkg::PWR_SPI_BIT] && spi_act) wake_hit = 1'b1;
    if (pwr_q[pwr_wake_pkg::PWR_HOSTP_BIT] && host_act) wake_hit = 1'b1;
    if (pwr_q[pwr_wake_pkg::PWR_GP_BIT] && gp_act) wake_hit = 1'b1;
  end

  // Wake enables only count while asleep
  assign sleep_exit = wake_hit && (state_q == pwr_wake_pkg::PM_SLEEP);

  // ************************************************************
  // Interrupt gating
  // ************************************************************
  pwr_wake_pkg::irq_vec_t gated;

  always_comb begin
    gated                      = '0;
    gated.otg_change_vector    = irq_pending.otg_change_vector & ie_q[pwr_wake_pkg::IE_OTG_BIT];
    gated.spi                  = irq_pending.spi & {3{ie_q[pwr_wake_pkg::IE_SPI_BIT]}};
    gated.usb2                 = irq_pending.usb2 & {8{ie_q[pwr_wake_pkg::IE_USB2_BIT]}};
    gated.usb1                 = irq_pending.usb1 & {8{ie_q[pwr_wake_pkg::IE_USB1_BIT]}};
    gated.fsp                  = irq_pending.fsp & {2{ie_q[pwr_wake_pkg::IE_FSP_BIT]}};
    gated.inbound_mailbox_irq  = irq_pending.inbound_mailbox_irq & ie_q[pwr_wake_pkg::IE_MBOX_IN_BIT];
    gated.outbound_mailbox_irq = irq_pending.outbound_mailbox_irq & ie_q[pwr_wake_pkg::IE_MBOX_OUT_BIT];
    gated.uart                 = irq_pending.uart & {2{ie_q[pwr_wake_pkg::IE_UART_BIT]}};
    gated.gpio                 = irq_pending.gpio & ie_q[pwr_wake_pkg::IE_GPIO_BIT];
    gated.timer1_irq           = irq_pending.timer1_irq & ie_q[pwr_wake_pkg::IE_TMR1_BIT];
    gated.timer0_irq           = irq_pending.timer0_irq & ie_q[pwr_wake_pkg::IE_TMR0_BIT];
  end

  assign any_irq = |gated;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_req <= '0;
    end else begin
      irq_req <= gated;
    end
  end

  // Pending clear pulses when the GPIO or a timer enable falls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gp_pend_clr <= 1'b0;
    end else begin
      gp_pend_clr <= wr_ie && ie_q[pwr_wake_pkg::IE_GPIO_BIT] && !ie_d[pwr_wake_pkg::IE_GPIO_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tmr1_pend_clr <= 1'b0;
    end else begin
      tmr1_pend_clr <= wr_ie && ie_q[pwr_wake_pkg::IE_TMR1_BIT] && !ie_d[pwr_wake_pkg::IE_TMR1_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tmr0_pend_clr <= 1'b0;
    end else begin
      tmr0_pend_clr <= wr_ie && ie_q[pwr_wake_pkg::IE_TMR0_BIT] && !ie_d[pwr_wake_pkg::IE_TMR0_BIT];
    end
  end

  // ************************************************************
  // Power mode machine
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= pwr_wake_pkg::PM_RUN;
      resume_cnt_q <= '0;
    end else begin
      case (state_q)
        pwr_wake_pkg::PM_RUN: begin
          if (sleep_wr) begin
            state_q <= pwr_wake_pkg::PM_SLEEP;
          end else if (halt_wr) begin
            state_q <= pwr_wake_pkg::PM_HALT;
          end
        end
        pwr_wake_pkg::PM_HALT: begin
          if (any_irq) begin
            state_q <= pwr_wake_pkg::PM_RUN;
          end
        end
        pwr_wake_pkg::PM_SLEEP: begin
          if (wake_hit) begin
            state_q      <= pwr_wake_pkg::PM_RESUME;
            resume_cnt_q <= '0;
          end
        end
        pwr_wake_pkg::PM_RESUME: begin
          if (resume_cnt_q >= 32'(RESUME_CYCLES - 1)) begin
            state_q <= pwr_wake_pkg::PM_RUN;
          end else begin
            resume_cnt_q <= resume_cnt_q + 32'd1;
          end
        end
        default: begin
          state_q <= pwr_wake_pkg::PM_RUN;
        end
      endcase
    end
  end

  // ************************************************************
  // Power outputs and discard flags
  // ************************************************************
  // CPU stops for halt and sleep and waits out the resume count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_run <= 1'b1;
    end else begin
      cpu_run <= (state_q == pwr_wake_pkg::PM_RUN) && !sleep_wr && !halt_wr;
    end
  end

  // Clock restarts at the wake edge so the resume count can run
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_gate_en <= 1'b1;
    end else begin
      clk_gate_en <= ((state_q != pwr_wake_pkg::PM_SLEEP) && !sleep_wr) || sleep_exit;
    end
  end

  // Booster, charge pump and transceivers off in sleep
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      analog_pwr_en <= 1'b1;
    end else begin
      analog_pwr_en <= ((state_q != pwr_wake_pkg::PM_SLEEP) && !sleep_wr) || sleep_exit;
    end
  end

  // Byte that caused the wake is dropped by the serial ports
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fsp_discard <= 1'b0;
    end else if (sleep_exit) begin
      fsp_discard <= pwr_q[pwr_wake_pkg::PWR_FSP_BIT] && fsp_act;
    end else if (state_q == pwr_wake_pkg::PM_RUN) begin
      fsp_discard <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      spi_discard <= 1'b0;
    end else if (sleep_exit) begin
      spi_discard <= pwr_q[pwr_wake_pkg::PWR_SPI_BIT] && spi_act;
    end else if (state_q == pwr_wake_pkg::PM_RUN) begin
      spi_discard <= 1'b0;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  logic [15:0] pwr_view;

  always_comb begin
    pwr_view                              = pwr_q;
    pwr_view[pwr_wake_pkg::PWR_BOOST_BIT] = boost_s;
    pwr_view[pwr_wake_pkg::PWR_SLEEP_BIT] = (state_q == pwr_wake_pkg::PM_SLEEP);
    pwr_view[pwr_wake_pkg::PWR_HALT_BIT]  = (state_q == pwr_wake_pkg::PM_HALT);
  end

  // Unmapped reads and idle cycles return zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == pwr_wake_pkg::PWR_CTRL_OFFSET) begin
      reg_rdata <= pwr_view;
    end else if (reg_rd && reg_addr == pwr_wake_pkg::IRQ_EN_OFFSET) begin
      reg_rdata <= ie_q;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// [hw/pwr_wake_pkg.sv]
// Constants, register layout and carrier types for the power and wake block.
// Assumes a 16-bit register port and a 250 MHz ref_clk.
package pwr_wake_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] PWR_CTRL_OFFSET = 16'hc00a;
  localparam logic [15:0] IRQ_EN_OFFSET   = 16'hc00e;

  // ************************************************************
  // Power control fields
  // ************************************************************
  localparam int PWR_HALT_BIT   = 0;
  localparam int PWR_SLEEP_BIT  = 1;
  localparam int PWR_BOOST_BIT  = 2;
  localparam int PWR_GP_BIT     = 4;
  localparam int PWR_HOSTP_BIT  = 7;
  localparam int PWR_SPI_BIT    = 8;
  localparam int PWR_FSP_BIT    = 9;
  localparam int PWR_OTG_BIT    = 11;
  localparam int PWR_USB1_BIT   = 12;
  localparam int PWR_USB2_BIT   = 14;
  localparam logic [15:0] PWR_WAKE_MASK = 16'h5b90;
  localparam logic [15:0] PWR_RESET     = 16'h0000;

  // ************************************************************
  // Interrupt enable fields
  // ************************************************************
  localparam int IE_TMR0_BIT  = 0;
  localparam int IE_TMR1_BIT  = 1;
  localparam int IE_GPIO_BIT  = 2;
  localparam int IE_UART_BIT  = 3;
  localparam int IE_MBOX_OUT_BIT = 5;
  localparam int IE_MBOX_IN_BIT  = 6;
  localparam int IE_FSP_BIT   = 7;
  localparam int IE_USB1_BIT  = 8;
  localparam int IE_USB2_BIT  = 9;
  localparam int IE_SPI_BIT   = 11;
  localparam int IE_OTG_BIT   = 12;
  localparam logic [15:0] IE_WR_MASK = 16'h1bef;
  localparam logic [15:0] IE_RESET   = 16'h0000;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ        = 250;
  localparam int RESUME_US_X10  = 5000;
  localparam int RESUME_CYCLES  = (RESUME_US_X10 * CLK_MHZ) / 10;
  localparam int RESTART_CYCLES = 16;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic       usb2;
    logic       usb1;
    logic       bus_voltage_valid;
    logic       otg_id;
    logic       fsp_rx;
    logic       slave_select_n;
    logic       host_rd;
    logic [1:0] gp_pin;
  } wake_pins_t;

  typedef struct packed {
    logic       otg_change_vector;
    logic [2:0] spi;
    logic [7:0] usb2;
    logic [7:0] usb1;
    logic [1:0] fsp;
    logic       inbound_mailbox_irq;
    logic       outbound_mailbox_irq;
    logic [1:0] uart;
    logic       gpio;
    logic       timer1_irq;
    logic       timer0_irq;
  } irq_vec_t;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_HALT,
    PM_SLEEP,
    PM_RESUME
  } pm_state_t;

endpackage
